/* design/htr_pkg.sv */
// Package of constants and carrier types for the HDLC timeslot router
package htr_pkg;
  // ==========================================================================
  // Register map
  localparam logic [7:0] HTR_ADDR_RX_ROUTE = 8'hB8;
  localparam logic [7:0] HTR_ADDR_RX_MASK  = 8'hB9;
  localparam logic [7:0] HTR_ADDR_TX_ROUTE = 8'hBA;
  localparam logic [7:0] HTR_ADDR_TX_MASK  = 8'hBB;
  localparam logic [7:0] HTR_RESET_VALUE   = 8'h00;
  // ==========================================================================
  // Route register fields
  localparam int HTR_BIT_SOURCE  = 7;
  localparam int HTR_BIT_SA_SLOT = 6;
  localparam int HTR_BIT_MODE    = 5;
  localparam int HTR_FIELD_MSB   = 4;
  // ==========================================================================
  // Frame geometry
  localparam int          HTR_SLOTS       = 32;
  localparam int          HTR_SA_COUNT    = 5;
  localparam logic [4:0]  HTR_SA_SLOT     = 5'h00;
  localparam logic [2:0]  HTR_SA4_BITPOS  = 3'h3;
  localparam logic [2:0]  HTR_DS0_LAST_BIT = 3'h7;

  typedef struct packed {
    logic       frame_odd;
    logic [4:0] slot;
    logic [2:0] bit_pos;
  } htr_pos_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } htr_cpu_type;
endpackage : htr_pkg

/* design/htr_bit_select.sv */
// Per-bit selection decode shared by receive and transmit paths
`timescale 1ns/1ps
module htr_bit_select (
  input  wire htr_pkg::htr_pos_type pos_in,
  input  wire logic [7:0]           route_in,
  input  wire logic [7:0]           mask_in,
  input  wire logic [31:0]          chan_blk_in,
  input  wire logic                 sa_use_route_in,
  input  wire logic [4:0]           sa_alt_in,
  output logic                      select_out
);
  import htr_pkg::*;

  logic [4:0] sa_en;
  logic [2:0] sa_idx;
  logic       slot_hit;
  logic       sa_hit;

  // ==========================================================================
  // Sa enables, bit 4 is Sa4 down to bit 0 Sa8
  assign sa_en    = sa_use_route_in ? route_in[HTR_FIELD_MSB:0] : sa_alt_in;
  assign sa_idx   = 3'(pos_in.bit_pos - HTR_SA4_BITPOS);
  assign sa_hit   = pos_in.frame_odd && (pos_in.slot == HTR_SA_SLOT) &&
                    (pos_in.bit_pos >= HTR_SA4_BITPOS) &&
                    sa_en[3'(HTR_SA_COUNT - 1) - sa_idx];
  // ==========================================================================
  // Timeslot match, single field or channel block
  assign slot_hit = route_in[HTR_BIT_MODE] ? chan_blk_in[pos_in.slot]
                                           : (pos_in.slot == route_in[HTR_FIELD_MSB:0]);

  always_comb begin
    if (!sa_use_route_in || !route_in[HTR_BIT_SA_SLOT]) begin
      select_out = sa_hit;
    end else begin
      select_out = slot_hit && !mask_in[HTR_DS0_LAST_BIT - pos_in.bit_pos];
    end
  end
endmodule : htr_bit_select

/* design/htr_router.sv */
// Top of the HDLC timeslot router for one framer
//
// Operation
// RL1 - Source bit 0 takes Sa bits from control-two register; 1 uses route register.
// RL2 - Receive route bit 6: 0 feeds Sa bits, 1 feeds DS0 channel bits.
// RL3 - Receive Sa mode: bits 4..0 enable Sa4..Sa8 positions.
// RL4 - Receive DS0 mode bit 5 set: timeslots from receive channel-block registers.
// RL5 - Receive DS0 mode bit 5 clear: single timeslot numbered by bits 4..0.
// RL6 - Receive mask bits 7..0 suppress DS0 bits 1..8.
// RL7 - Transmit enable bit 7 clear: no HDLC data inserted.
// RL8 - Transmit bit 6 picks Sa or DS0; ignored while disabled.
// RL9 - Transmit Sa mode: bits 4..0 enable Sa4..Sa8 insertion.
// RL10 - Transmit DS0 mode bit 5 set: timeslots from transmit channel-block registers.
// RL11 - Transmit DS0 mode bit 5 clear: single timeslot numbered by bits 4..0.
// RL12 - Transmit mask register at BB suppresses DS0 bits from insertion.
// RL13 - Unselected bits pass framer data; HDLC stream skips them without loss.
`timescale 1ns/1ps
module htr_router #(
  parameter int SLOT_COUNT = htr_pkg::HTR_SLOTS
) (
  input  wire logic                 sys_clk_in,
  input  wire logic                 reset_n_in,
  input  wire htr_pkg::htr_cpu_type cpu_in,
  output logic [7:0]                cpu_rdata_out,
  input  wire logic [4:0]           rx_control_two_in,
  input  wire logic [31:0]          rx_channel_block_regs_in,
  input  wire logic [31:0]          tx_channel_block_regs_in,
  input  wire logic                 rx_bit_valid_in,
  input  wire htr_pkg::htr_pos_type rx_pos_in,
  input  wire logic                 rx_bit_in,
  output logic                      rx_hdlc_valid_out,
  output logic                      rx_hdlc_bit_out,
  input  wire logic                 tx_bit_valid_in,
  input  wire htr_pkg::htr_pos_type tx_pos_in,
  input  wire logic                 tx_bit_in,
  input  wire logic                 tx_hdlc_bit_in,
  output logic                      tx_hdlc_take_out,
  output logic                      tx_bit_valid_out,
  output logic                      tx_bit_out
);
  import htr_pkg::*;

  // ==========================================================================
  // Configuration registers
  logic [7:0] rx_hdlc_route_ctrl;
  logic [7:0] rx_hdlc_bit_mask;
  logic [7:0] tx_hdlc_route_ctrl;
  logic [7:0] tx_hdlc_bit_mask;

  // ==========================================================================
  // Bus decode
  logic       wr_rx_route;
  logic       wr_rx_mask;
  logic       wr_tx_route;
  logic       wr_tx_mask;
  logic [7:0] next_rdata;

  // ==========================================================================
  // Selection and stream nets
  logic       rx_source_sel;
  logic       tx_enable;
  logic       rx_sel;
  logic       tx_sel;
  logic       next_rx_valid;
  logic       next_tx_bit;

  // ==========================================================================
  // Elaboration checks; the slot field is five bits wide
  if (SLOT_COUNT != HTR_SLOTS) begin : g_bad_slot_count
    $error("htr_router: SLOT_COUNT must equal HTR_SLOTS");
  end
  if ($bits(rx_channel_block_regs_in) != SLOT_COUNT) begin : g_bad_rx_blk
    $error("htr_router: receive channel block width must equal SLOT_COUNT");
  end
  if ($bits(tx_channel_block_regs_in) != SLOT_COUNT) begin : g_bad_tx_blk
    $error("htr_router: transmit channel block width must equal SLOT_COUNT");
  end

  // ==========================================================================
  // Write strobes, one per register
  assign wr_rx_route = cpu_in.wr && (cpu_in.addr == HTR_ADDR_RX_ROUTE);
  assign wr_rx_mask  = cpu_in.wr && (cpu_in.addr == HTR_ADDR_RX_MASK);
  assign wr_tx_route = cpu_in.wr && (cpu_in.addr == HTR_ADDR_TX_ROUTE);
  assign wr_tx_mask  = cpu_in.wr && (cpu_in.addr == HTR_ADDR_TX_MASK); // RL12

  // ==========================================================================
  // Receive route register
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_hdlc_route_ctrl <= HTR_RESET_VALUE;
    end else if (wr_rx_route) begin
      rx_hdlc_route_ctrl <= cpu_in.wdata;
    end
  end

  // ==========================================================================
  // Receive bit mask register
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_hdlc_bit_mask <= HTR_RESET_VALUE;
    end else if (wr_rx_mask) begin
      rx_hdlc_bit_mask <= cpu_in.wdata; // RL6
    end
  end

  // ==========================================================================
  // Transmit route register
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_hdlc_route_ctrl <= HTR_RESET_VALUE;
    end else if (wr_tx_route) begin
      tx_hdlc_route_ctrl <= cpu_in.wdata;
    end
  end

  // ==========================================================================
  // Transmit bit mask register
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_hdlc_bit_mask <= HTR_RESET_VALUE;
    end else if (wr_tx_mask) begin
      tx_hdlc_bit_mask <= cpu_in.wdata; // RL12
    end
  end

  // ==========================================================================
  // Read data select; unmapped addresses read as zero
  always_comb begin
    case (cpu_in.addr)
      HTR_ADDR_RX_ROUTE: next_rdata = rx_hdlc_route_ctrl;
      HTR_ADDR_RX_MASK:  next_rdata = rx_hdlc_bit_mask;
      HTR_ADDR_TX_ROUTE: next_rdata = tx_hdlc_route_ctrl;
      HTR_ADDR_TX_MASK:  next_rdata = tx_hdlc_bit_mask;
      default:           next_rdata = HTR_RESET_VALUE;
    endcase
  end

  // ==========================================================================
  // Read data register, holds until the next read
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cpu_rdata_out <= HTR_RESET_VALUE;
    end else if (cpu_in.rd) begin
      cpu_rdata_out <= next_rdata;
    end
  end

  // ==========================================================================
  // Control bits used outside the selectors
  assign rx_source_sel = rx_hdlc_route_ctrl[HTR_BIT_SOURCE]; // RL1
  assign tx_enable     = tx_hdlc_route_ctrl[HTR_BIT_SOURCE]; // RL7 RL8

  // ==========================================================================
  // Receive selection
  htr_bit_select u_rx_sel (
    .pos_in          (rx_pos_in),
    .route_in        (rx_hdlc_route_ctrl),
    .mask_in         (rx_hdlc_bit_mask),                   // RL6
    .chan_blk_in     (rx_channel_block_regs_in),           // RL4
    .sa_use_route_in (rx_source_sel),                      // RL1
    .sa_alt_in       (rx_control_two_in),
    .select_out      (rx_sel)                              // RL2 RL3 RL5
  );

  // ==========================================================================
  // Transmit selection
  htr_bit_select u_tx_sel (
    .pos_in          (tx_pos_in),
    .route_in        (tx_hdlc_route_ctrl),                 // RL8 RL9 RL11
    .mask_in         (tx_hdlc_bit_mask),                   // RL12
    .chan_blk_in     (tx_channel_block_regs_in),           // RL10
    .sa_use_route_in (1'b1),
    .sa_alt_in       (5'h00),
    .select_out      (tx_sel)
  );

  // ==========================================================================
  // Receive valid to HDLC controller
  assign next_rx_valid = rx_bit_valid_in && rx_sel; // RL13

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_hdlc_valid_out <= 1'b0;
    end else begin
      rx_hdlc_valid_out <= next_rx_valid;
    end
  end

  // ==========================================================================
  // Receive data bit
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_hdlc_bit_out <= 1'b0;
    end else begin
      rx_hdlc_bit_out <= rx_bit_in;
    end
  end

  // ==========================================================================
  // Transmit insertion; HDLC bit consumed only when inserted
  assign tx_hdlc_take_out = tx_bit_valid_in && tx_sel && tx_enable;          // RL7 RL13
  assign next_tx_bit      = tx_hdlc_take_out ? tx_hdlc_bit_in : tx_bit_in; // RL7 RL13

  // ==========================================================================
  // Transmit valid
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_bit_valid_out <= 1'b0;
    end else begin
      tx_bit_valid_out <= tx_bit_valid_in;
    end
  end

  // ==========================================================================
  // Transmit data bit
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_bit_out <= 1'b0;
    end else begin
      tx_bit_out <= next_tx_bit;
    end
  end
endmodule : htr_router

/* verification/htr_hdlc_src.sv */
// HDLC transmit bit source model
`timescale 1ns/1ps
module htr_hdlc_src (
  input  wire logic sys_clk_in,
  input  wire logic reset_n_in,
  input  wire logic take_in,
  output logic      bit_out
);
  logic [7:0] cnt;
  assign bit_out = cnt[0] ^ cnt[2];
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) cnt <= 8'h00;
    else if (take_in) cnt <= cnt + 8'h01;
  end
endmodule : htr_hdlc_src

/* verification/htr_router_asserts.sv */
// Port-level assertions for the HDLC timeslot router
`timescale 1ns/1ps
module htr_router_asserts
  import htr_pkg::*;
(
  input wire logic        sys_clk_in,
  input wire logic        reset_n_in,
  input wire htr_pkg::htr_cpu_type cpu_in,
  input wire logic [7:0]  cpu_rdata_out,
  input wire logic        rx_bit_valid_in,
  input wire logic        rx_bit_in,
  input wire logic        rx_hdlc_valid_out,
  input wire logic        rx_hdlc_bit_out,
  input wire logic        tx_bit_valid_in,
  input wire logic        tx_bit_in,
  input wire logic        tx_hdlc_bit_in,
  input wire logic        tx_hdlc_take_out,
  input wire logic        tx_bit_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  property p_take; tx_hdlc_take_out |-> tx_bit_valid_in; endproperty
  a_take: assert property (p_take) else $error("take without bit");
  property p_pass; tx_bit_valid_in && !tx_hdlc_take_out |=> tx_bit_out == $past(tx_bit_in); endproperty
  a_pass: assert property (p_pass) else $error("framer bit altered");
  property p_ins; tx_hdlc_take_out |=> tx_bit_out == $past(tx_hdlc_bit_in); endproperty
  a_ins: assert property (p_ins) else $error("hdlc bit not inserted");
  property p_rxc; rx_hdlc_valid_out |-> $past(rx_bit_valid_in); endproperty
  a_rxc: assert property (p_rxc) else $error("rx bit without cause");
  property p_rxd; rx_hdlc_valid_out |-> rx_hdlc_bit_out == $past(rx_bit_in); endproperty
  a_rxd: assert property (p_rxd) else $error("rx bit value");
  property p_hold; !$past(cpu_in.rd) |-> $stable(cpu_rdata_out); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_wr; cpu_in.wr && cpu_in.addr[7:2] == 6'h2E ##2 cpu_in.rd && cpu_in.addr == $past(cpu_in.addr, 2)
    |=> cpu_rdata_out == $past(cpu_in.wdata, 3); endproperty
  a_wr: assert property (p_wr) else $error("readback differs");
  property p_unm; cpu_in.rd && cpu_in.addr[7:2] != 6'h2E |=> cpu_rdata_out == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  c_take: cover property (tx_hdlc_take_out);
  c_rx: cover property (rx_hdlc_valid_out);
  c_unm: cover property (cpu_in.rd && cpu_in.addr == 8'hBC);
endmodule : htr_router_asserts
bind htr_router htr_router_asserts chk_i (.*);

/* verification/testbench.sv */
// Self-checking bench for the HDLC timeslot router
`timescale 1ns/1ps
module testbench;
  import htr_pkg::*;
  logic        sys_clk_in, reset_n_in, rxv, rxb, txv, txb, hb, take, rvo, rbo, tvo, tbo, prx, pb, pv, ptb;
  htr_cpu_type cpu;
  htr_pos_type pos;
  logic [7:0]  rd, rr, rm, tr, tm, c2, ti;
  logic [31:0] rb, tb;
  int          error_cnt, n_tests;
  logic [103:0] cfg [4] = '{104'h5F007F0015_00000000_FFFFFFFF, 104'h9AFF85FF1F_FFFFFFFF_FFFFFFFF,
                            104'hC581DF4200_FFFFFFFF_00000000, 104'hE018E00000_80000003_00010001};
  htr_router dut (.sys_clk_in, .reset_n_in, .cpu_in(cpu), .cpu_rdata_out(rd), .rx_control_two_in(c2[4:0]),
    .rx_channel_block_regs_in(rb), .tx_channel_block_regs_in(tb), .rx_bit_valid_in(rxv), .rx_pos_in(pos),
    .rx_bit_in(rxb), .rx_hdlc_valid_out(rvo), .rx_hdlc_bit_out(rbo), .tx_bit_valid_in(txv), .tx_pos_in(pos),
    .tx_bit_in(txb), .tx_hdlc_bit_in(hb), .tx_hdlc_take_out(take), .tx_bit_valid_out(tvo), .tx_bit_out(tbo));
  htr_hdlc_src partner (.sys_clk_in, .reset_n_in, .take_in(take), .bit_out(hb));
  initial begin
    sys_clk_in = 0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  task automatic end_sim;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic cpu_op(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge sys_clk_in) cpu <= '{a, d, w, !w};
    @(posedge sys_clk_in) cpu <= '0;
    #1;
  endtask : cpu_op
  function automatic logic sel(logic [7:0] r, logic [7:0] m, logic [31:0] b, logic tx, htr_pos_type p);
    logic sa;
    sa = p.frame_odd && p.slot == 5'h00 && p.bit_pos >= 3'h3;
    if (!r[7]) return !tx && sa && c2[7 - p.bit_pos];
    if (!r[6]) return sa && r[7 - p.bit_pos];
    return (r[5] ? b[p.slot] : p.slot == r[4:0]) && !m[7 - p.bit_pos];
  endfunction : sel
  task automatic step(input htr_pos_type p, input logic v);
    logic er, et, rn, tn;
    er = v && sel(rr, rm, rb, 1'b0, p);
    et = v && sel(tr, tm, tb, 1'b1, p);
    rn = p.slot[0] ^ p.bit_pos[1];
    tn = ~(p.slot[2] ^ p.bit_pos[0]);
    @(posedge sys_clk_in);
    pos <= p;
    rxv <= v;
    txv <= v;
    rxb <= rn;
    txb <= tn;
    @(negedge sys_clk_in);
    chk(take, et);
    chk(rvo, prx);
    if (prx) chk(rbo, pb);
    if (pv) chk(tbo, ptb);
    chk(tvo, pv);
    prx = er;
    pb = rn;
    pv = v;
    ptb = et ? ti[0] ^ ti[2] : tn;
    if (et) ti++;
  endtask : step
  initial begin
    {reset_n_in, cpu, pos, rxv, rxb, txv, txb, prx, pv, ti, c2, rb, tb} = '0;
    repeat (12) @(posedge sys_clk_in);
    reset_n_in <= 1;
    cpu_op(8'hBC, 8'hFF, 1);
    for (int a = 8'hB8; a < 8'hBD; a++) begin
      cpu_op(a[7:0], 8'h00, 0);
      chk(rd, HTR_RESET_VALUE);
    end
    foreach (cfg[i]) begin
      @(posedge sys_clk_in) {rr, rm, tr, tm, c2, rb, tb} <= cfg[i];
      for (int k = 0; k < 4; k++) begin
        cpu_op(HTR_ADDR_RX_ROUTE + k[7:0], cfg[i][103 - 8 * k -: 8], 1);
        cpu_op(HTR_ADDR_RX_ROUTE + k[7:0], 8'h00, 0);
        chk(rd, cfg[i][103 - 8 * k -: 8]);
      end
      for (int f = 0; f < 2; f++)
        for (int s = 0; s < 32; s++)
          for (int b = 0; b < 8; b++) step('{f[0], s[4:0], b[2:0]}, 1);
      step('0, 0);
      step('0, 0);
    end
    end_sim();
  end
  initial begin
    #100000;
    error_cnt++;
    end_sim();
  end
endmodule : testbench
